//--- nvmc_control.sv
// Summary of operation
// (R1) Error flag bit 3 sets on aborted cycle or improper write attempt.
// (R2) Error flag reads 0 after a normally completed cycle.
// (R3) Erase/write cycles start only while the write gate bit is 1.
// (R4) Setting the cycle bit starts EEPROM, row erase or flash write cycle.
// (R5) Cycle is timed internally; hardware clears cycle bit when done.
// (R6) Software may only set the cycle bit; writing 0 does nothing.
// (R7) On error the memory and config select bits stay unchanged; the code keeps them on abort only, an improper write loads them.
// (R8) Read bit launches one-cycle EEPROM read, self-clears, ignored for flash.
// (R9) Row-erase bit selects erase; completion of erase clears it.
// (R10) Completion sets the cycle-done interrupt flag bit 4.
// (R11) Memory select 1 is flash, 0 EEPROM; gate clears at power-up.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module nvmc_control
    import nvmc_pkg::*;
#(
    parameter int CYCLE_CLKS = NVMC_CYCLE_CLKS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        abort_req,
    output logic             nvm_start,
    output logic             nvm_busy,
    output logic             nvm_erase,
    output logic             nvm_space,
    output logic             nvm_cfg,
    output logic             nvm_read,
    output logic             irq
);

    // ==========================================================
    // Bus slave
    logic              dp_write;
    logic [7:0]        dp_addr;
    logic [7:0]        next_rdata;
    wire logic         take;
    wire logic         wr_ctrl;
    wire logic         wr_clear;
    wire logic         wr_enable;

    // Zero wait state; hsize unused, word access only
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign take      = hsel & htrans[1] & hready;
    assign wr_ctrl   = dp_write & (dp_addr == NVMC_OFF_CONTROL);
    assign wr_clear  = dp_write & (dp_addr == NVMC_OFF_CLEAR);
    assign wr_enable = dp_write & (dp_addr == NVMC_OFF_ENABLE);

    always_ff @(posedge clk) begin
        if (rst) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= take & hwrite;
            dp_addr  <= haddr[7:0];
        end
    end

    // ==========================================================
    // Control register fields
    nvmc_state_t          state;
    logic [NVMC_CNT_W-1:0] cnt;
    logic                 mem_sel;
    logic                 cfg_sel;
    logic                 row_erase;
    logic                 err;
    logic                 gate;
    logic                 rd;
    logic [7:0]           irq_stat;
    logic [7:0]           irq_en;
    logic [7:0]           next_irq_stat;
    logic                 next_err;
    wire logic            idle;
    wire logic            wr_bit;
    wire logic            wr_req;
    wire logic            start_ok;
    wire logic            improper;
    wire logic            abort;
    wire logic            done;
    wire logic            rd_req;
    wire logic [7:0]      ctrl_view;
    wire logic [7:0]      ev;

    assign idle     = (state == NVMC_IDLE);
    assign wr_bit   = ~idle;                                  // R5
    // Control writes during a cycle are dropped so the cycle sees
    // stable selects; a 0 in the cycle bit never stops it
    assign wr_req   = wr_ctrl & hwdata[NVMC_BIT_WR] & idle;   // R6
    // Gate is taken as it stood before this write: open it first
    assign start_ok = wr_req & gate;                          // R3 R4
    assign improper = wr_req & ~gate;                         // R3
    assign abort    = abort_req & ~idle;                      // R1
    // Abort wins over completion on the last count
    assign done     = ~idle & (cnt == '0) & ~abort_req;       // R5
    assign rd_req   = wr_ctrl & idle & hwdata[NVMC_BIT_RD]
                      & ~hwdata[NVMC_BIT_MEM_SEL];            // R8

    assign ctrl_view = {mem_sel, cfg_sel, 1'b0, row_erase,
                        err, gate, wr_bit, rd};

    // ==========================================================
    // Cycle sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= NVMC_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                NVMC_IDLE: begin
                    if (start_ok) begin                       // R4
                        state <= NVMC_PROG;
                        cnt   <= NVMC_CNT_W'(CYCLE_CLKS - 1);
                    end
                end
                NVMC_PROG: begin
                    if (abort || done) begin                  // R5
                        state <= NVMC_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= NVMC_IDLE;
                end
            endcase
        end
    end

    // Set wins over the completion clear
    always_comb begin
        next_err = err;
        if (improper || abort) begin
            next_err = 1'b1;                                  // R1
        end else if (done) begin
            next_err = 1'b0;                                  // R2
        end else if (wr_ctrl && idle) begin
            next_err = hwdata[NVMC_BIT_ERR];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_sel   <= NVMC_CONTROL_RST[NVMC_BIT_MEM_SEL];
            cfg_sel   <= NVMC_CONTROL_RST[NVMC_BIT_CFG_SEL];
            row_erase <= NVMC_CONTROL_RST[NVMC_BIT_ROW_ERASE];
            gate      <= NVMC_CONTROL_RST[NVMC_BIT_GATE];     // R11
            err       <= NVMC_CONTROL_RST[NVMC_BIT_ERR];
            rd        <= NVMC_CONTROL_RST[NVMC_BIT_RD];
        end else begin
            err <= next_err;
            rd  <= rd_req;                                    // R8
            // Abort leaves the selects alone for tracing
            if (wr_ctrl && idle) begin                        // R7
                mem_sel   <= hwdata[NVMC_BIT_MEM_SEL];        // R11
                cfg_sel   <= hwdata[NVMC_BIT_CFG_SEL];
                row_erase <= hwdata[NVMC_BIT_ROW_ERASE];
                gate      <= hwdata[NVMC_BIT_GATE];
            end else if (done && row_erase) begin
                row_erase <= 1'b0;                            // R9
            end
        end
    end

    // ==========================================================
    // Array side strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            nvm_start <= 1'b0;
            nvm_read  <= 1'b0;
        end else begin
            nvm_start <= start_ok;                            // R4
            nvm_read  <= rd_req;                              // R8
        end
    end

    assign nvm_busy  = wr_bit;
    assign nvm_erase = row_erase & mem_sel;                   // R9
    assign nvm_space = mem_sel;
    assign nvm_cfg   = cfg_sel;

    // ==========================================================
    // Interrupts
    assign ev = {3'b000, done, improper | abort, 3'b000};     // R10

    // Event in the same cycle as its clear is kept
    always_comb begin
        next_irq_stat = irq_stat;
        if (wr_clear) begin
            next_irq_stat = irq_stat & ~hwdata[7:0];
        end
        next_irq_stat = next_irq_stat | ev;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat <= NVMC_IRQ_RST;
            irq_en   <= NVMC_IRQ_RST;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            // From next status, so irq moves on the same edge
            irq      <= |(next_irq_stat & irq_en);
            if (wr_enable) begin
                irq_en <= hwdata[7:0] & 8'h18;
            end
        end
    end

    // ==========================================================
    // Read path, sampled in the address phase
    assign next_rdata =
        (haddr[7:0] == NVMC_OFF_CONTROL) ? ctrl_view :
        (haddr[7:0] == NVMC_OFF_STATUS)  ? irq_stat  :
        (haddr[7:0] == NVMC_OFF_ENABLE)  ? irq_en    : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= {24'h00_0000, next_rdata};
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_err_on_abort: assert property ( // R1
        abort || improper |=> err)
        else $error("error flag not set on aborted cycle");

    chk_err_clear_done: assert property ( // R2
        done |=> !err && !nvm_busy)
        else $error("error flag not cleared on completion");

    chk_gate_start: assert property ( // R3
        $rose(nvm_busy) |-> $past(gate) && nvm_start ##1 !nvm_start)
        else $error("cycle started with gate closed");

    chk_start_busy: assert property ( // R4
        start_ok |=> nvm_busy && nvm_start ##1 !nvm_start)
        else $error("start did not launch one cycle");

    chk_busy_hold: assert property ( // R6
        nvm_busy && !done && !abort |=> nvm_busy)
        else $error("cycle bit cleared before completion");

    chk_sel_kept: assert property ( // R7
        abort |=> $stable(mem_sel) && $stable(cfg_sel))
        else $error("selects changed on error");

    chk_read_pulse: assert property ( // R8
        rd |-> !mem_sel ##1 !rd)
        else $error("read bit not single cycle");

    chk_erase_clear: assert property ( // R9
        done && row_erase |=> !row_erase)
        else $error("row erase bit survived erase");

    chk_done_flag: assert property ( // R10
        done |=> irq_stat[NVMC_IRQ_DONE])
        else $error("done flag not set");

    chk_gate_reset: assert property ( // R11
        $past(rst) |-> !gate)
        else $error("gate not clear after reset");

    chk_count_load: assert property ( // R5
        start_ok |=> cnt == NVMC_CNT_W'(CYCLE_CLKS - 1))
        else $error("cycle timer not loaded");

    chk_busy_wr_drop: assert property ( // R6
        wr_ctrl && !idle |=> $stable(mem_sel) && $stable(gate))
        else $error("control write landed during a cycle");

    chk_flash_no_read: assert property ( // R8
        wr_ctrl && hwdata[NVMC_BIT_MEM_SEL] |=> !rd && !nvm_read)
        else $error("read launched with flash selected");

    cov_full_cycle: cover property (nvm_busy ##1 done);
    cov_busy_write: cover property (wr_ctrl && !idle);
    cov_abort: cover property (abort);
    cov_improper: cover property (improper);
    cov_read: cover property (rd_req);

endmodule : nvmc_control

`default_nettype wire

//--- nvmc_pkg.sv
package nvmc_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] NVMC_OFF_CONTROL = 8'h00;
    localparam logic [7:0] NVMC_OFF_STATUS  = 8'h04;
    localparam logic [7:0] NVMC_OFF_CLEAR   = 8'h08;
    localparam logic [7:0] NVMC_OFF_ENABLE  = 8'h0c;

    // ==========================================================
    // Control register field positions
    localparam int NVMC_BIT_MEM_SEL   = 7;
    localparam int NVMC_BIT_CFG_SEL   = 6;
    localparam int NVMC_BIT_ROW_ERASE = 4;
    localparam int NVMC_BIT_ERR       = 3;
    localparam int NVMC_BIT_GATE      = 2;
    localparam int NVMC_BIT_WR        = 1;
    localparam int NVMC_BIT_RD        = 0;

    // Interrupt status / clear / enable layout
    localparam int NVMC_IRQ_DONE = 4;
    localparam int NVMC_IRQ_ERR  = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0] NVMC_CONTROL_RST = 8'h00;
    localparam logic [7:0] NVMC_IRQ_RST     = 8'h00;

    // ==========================================================
    // Timing
    localparam int NVMC_CLK_PERIOD_NS = 8;
    localparam int NVMC_CYCLE_TIME_NS = 2000000;
    localparam int NVMC_CYCLE_CLKS    = NVMC_CYCLE_TIME_NS
                                        / NVMC_CLK_PERIOD_NS;
    localparam int NVMC_CNT_W         = 18;

    typedef enum logic {
        NVMC_IDLE,
        NVMC_PROG
    } nvmc_state_t;

endpackage : nvmc_pkg

//--- nvmc_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import nvmc_pkg::*;
;
    // ==========================================================
    // Signals
    logic        clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        abort_req;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         nvm_start;
    wire         nvm_busy;
    wire         nvm_erase;
    wire         nvm_space;
    wire         nvm_cfg;
    wire         nvm_read;
    wire         irq;
    int          fail_count;
    int          n_tests;
    int          n_start;
    int          n_read;
    int          n_busy;
    logic [31:0] rd;

    // Short cycle keeps the run brief
    nvmc_control #(.CYCLE_CLKS(8)) dut_u (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .abort_req(abort_req),
        .nvm_start(nvm_start), .nvm_busy(nvm_busy),
        .nvm_erase(nvm_erase), .nvm_space(nvm_space),
        .nvm_cfg(nvm_cfg), .nvm_read(nvm_read), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (nvm_start === 1'b1) n_start++;
        if (nvm_read === 1'b1) n_read++;
        if (nvm_busy === 1'b1) n_busy++;
    end

    // ==========================================================
    // Bus tasks
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000, rd);
        check(rd, exp, "register read");
    endtask : rchk

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #(20000 * 8);
        fail_count++;
        end_of_test();
    end

    // ==========================================================
    // Tests
    initial begin
        fail_count = 0; n_tests = 0; n_start = 0; n_read = 0; n_busy = 0;
        rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = '0; abort_req = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(NVMC_OFF_CONTROL, 32'h0000_0000);
        rchk(NVMC_OFF_STATUS, 32'h0000_0000);
        rchk(8'h10, 32'h0000_0000);
        wr(8'h10, 32'h0000_00ff);
        // Improper attempt: gate closed
        wr(NVMC_OFF_CONTROL, 32'h0000_0002);
        repeat (3) @(posedge clk);
        check(n_start, 0, "start while gated");
        rchk(NVMC_OFF_CONTROL, 32'h0000_0008);
        rchk(NVMC_OFF_STATUS, 32'h0000_0008);
        wr(NVMC_OFF_ENABLE, 32'h0000_0008);
        repeat (2) @(posedge clk);
        check(irq, 1'b1, "irq on error");
        wr(NVMC_OFF_CLEAR, 32'h0000_0008);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "irq cleared");
        wr(NVMC_OFF_ENABLE, 32'h0000_0010);
        // Flash row erase, with a clearing write while busy
        n_busy = 0;
        wr(NVMC_OFF_CONTROL, 32'h0000_009c);
        wr(NVMC_OFF_CONTROL, 32'h0000_009e);
        rchk(NVMC_OFF_CONTROL, 32'h0000_009e);
        check(nvm_erase, 1'b1, "erase level");
        wr(NVMC_OFF_CONTROL, 32'h0000_0000);
        for (int i = 0; i < 50 && nvm_busy === 1'b1; i++) @(posedge clk);
        check(n_start, 1, "start pulses");
        check(n_busy, 8, "busy cycles");
        rchk(NVMC_OFF_CONTROL, 32'h0000_0084);
        rchk(NVMC_OFF_STATUS, 32'h0000_0010);
        check(irq, 1'b1, "irq on done");
        wr(NVMC_OFF_CLEAR, 32'h0000_0010);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "irq done cleared");
        // EEPROM cycle cut short by abort
        wr(NVMC_OFF_CONTROL, 32'h0000_0046);
        @(posedge clk);
        abort_req <= 1'b1;
        @(posedge clk);
        abort_req <= 1'b0;
        repeat (2) @(posedge clk);
        check(nvm_busy, 1'b0, "busy after abort");
        rchk(NVMC_OFF_CONTROL, 32'h0000_004c);
        check(nvm_cfg, 1'b1, "config select kept");
        rchk(NVMC_OFF_STATUS, 32'h0000_0008);
        check(irq, 1'b0, "masked error");
        // Reads: EEPROM strobes, flash ignored
        wr(NVMC_OFF_CONTROL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check(n_read, 1, "eeprom read");
        rchk(NVMC_OFF_CONTROL, 32'h0000_0000);
        wr(NVMC_OFF_CONTROL, 32'h0000_0081);
        repeat (2) @(posedge clk);
        check(n_read, 1, "flash read ignored");
        rchk(NVMC_OFF_CONTROL, 32'h0000_0080);
        check(nvm_space, 1'b1, "space select");
        check(hresp, 1'b0, "response okay");
        end_of_test();
    end

endmodule : tb

`default_nettype wire
